//--- common/sto_consts.vh
// constants for the safe torque off interlock
`ifndef STO_CONSTS_VH
`define STO_CONSTS_VH
// register byte offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc
// control register fields
`define CTRL_SERVO_ON_BIT 0
`define CTRL_ALARM_CLR_BIT 1
// irq status fields
`define IRQ_TORQUE_OFF_BIT 0
`define IRQ_SKEW_BIT 1
`define IRQ_WIDTH 2
// reset values
`define CTRL_RESET 32'h00000000
`define IRQ_MASK_RESET 2'h0
// timing
`define CLK_HZ 25000000
`define SKEW_TIME_S 10
// SKEW_TIME_S at CLK_HZ, sized to the 28-bit timer
`define SKEW_CYCLES 28'd250000000
// interlock states
`define ST_TORQUE_OFF 2'h0
`define ST_DRIVE_READY 2'h1
`define ST_SERVO_READY 2'h2
`endif

//--- hw/skew_timer.v
// discrepancy timer between the two redundant safety inputs
`include "sto_consts.vh"

module skew_timer #(
  parameter CNT_W = 28,
  parameter [27:0] LIMIT = `SKEW_CYCLES
) (
  input wire clk_i,
  input wire nrst_i,
  input wire in_a_i,
  input wire in_b_i,
  output reg expired_o
);

  reg [CNT_W-1:0] cnt_ff;
  wire differ = in_a_i ^ in_b_i;

  // counts only while the inputs disagree; agreement clears it
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      expired_o <= 1'b0;
    end
    else if (!differ)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      expired_o <= 1'b0;
    end
    else if (cnt_ff < LIMIT)
    begin
      cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= 1'b1;
    end
  end

endmodule // skew_timer

//--- hw/sto_interlock.v
// safe torque off interlock with avalon-mm register slave
// How it works
// - both safety inputs off enters torque off
// - torque off cuts power stage in hardware
// - servo-on off keeps motor power off
// - torque off to drive ready when inputs on
// - drive ready to servo ready on servo-on
// - servo-on during torque off latches it
// - dropping servo-on releases latch to drive ready
// - inputs disagree ten seconds raises skew alarm
// - drive ready only when inputs on, servo-on off
// - monitor output only when both inputs off
`include "sto_consts.vh"

module sto_interlock #(
  parameter [27:0] SKEW_LIMIT = `SKEW_CYCLES
) (
  input wire REF_CLK_I,
  input wire NRST_I,
  input wire SAFETY_INPUT_A_I,
  input wire SAFETY_INPUT_B_I,
  input wire SERVO_ON_REQ_I,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  output reg POWER_ENABLE_O,
  output reg DRIVE_READY_O,
  output reg SERVO_READY_O,
  output reg EXTERNAL_MONITOR_OUT_O,
  output reg SAFETY_INPUT_SKEW_ALARM_O,
  output reg IRQ_O
);

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg sw_servo_on_ff;
  reg [1:0] irq_stat_ff;
  reg [1:0] irq_mask_ff;
  reg alarm_ff;
  reg acc_done_ff;
  wire expired;
  wire both_off;
  wire both_on;
  wire servo_on;
  wire [1:0] events;
  wire [1:0] clr_bits;
  wire wr_hit;
  wire [31:0] rd_mux;

  assign both_off = ~SAFETY_INPUT_A_I & ~SAFETY_INPUT_B_I;
  assign both_on = SAFETY_INPUT_A_I & SAFETY_INPUT_B_I;
  // servo-on needs both the pin and the software enable
  assign servo_on = SERVO_ON_REQ_I & sw_servo_on_ff;

  skew_timer #(
    .CNT_W(28),
    .LIMIT(SKEW_LIMIT)
  ) u_skew (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .in_a_i(SAFETY_INPUT_A_I),
    .in_b_i(SAFETY_INPUT_B_I),
    .expired_o(expired)
  );

  // interlock state transitions; the alarm takes no part here
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_TORQUE_OFF:
      begin
        // latched while servo-on stays high, even after inputs return
        if (!both_off && both_on && !servo_on)
          nxt_state = `ST_DRIVE_READY;
      end
      `ST_DRIVE_READY:
      begin
        if (!both_on)
          nxt_state = `ST_TORQUE_OFF;
        else if (servo_on)
          nxt_state = `ST_SERVO_READY;
      end
      `ST_SERVO_READY:
      begin
        if (!both_on)
          nxt_state = `ST_TORQUE_OFF;
        else if (!servo_on)
          nxt_state = `ST_DRIVE_READY;
      end
      default:
        nxt_state = `ST_TORQUE_OFF;
    endcase
    // both inputs off forces torque off at once from any state
    if (both_off)
      nxt_state = `ST_TORQUE_OFF;
  end

  // one pulse per event: torque off entry and skew alarm rising
  assign events[`IRQ_TORQUE_OFF_BIT] = (nxt_state == `ST_TORQUE_OFF) &&
                                       (state_ff != `ST_TORQUE_OFF);
  assign events[`IRQ_SKEW_BIT] = expired & ~alarm_ff;

  assign wr_hit = AVS_WRITE_I & ~acc_done_ff;
  assign clr_bits = (wr_hit && AVS_ADDRESS_I == `REG_IRQ_STAT && AVS_BYTEENABLE_I[0]) ?
                    AVS_WRITEDATA_I[1:0] : 2'h0;

  // state, outputs and alarm; power path depends on inputs, state and the software servo-on bit
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_ff <= `ST_TORQUE_OFF;
      POWER_ENABLE_O <= 1'b0;
      DRIVE_READY_O <= 1'b0;
      SERVO_READY_O <= 1'b0;
      EXTERNAL_MONITOR_OUT_O <= 1'b0;
      alarm_ff <= 1'b0;
      SAFETY_INPUT_SKEW_ALARM_O <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      // cut power when any input drops, without waiting for software
      POWER_ENABLE_O <= (nxt_state == `ST_SERVO_READY) & both_on & servo_on;
      DRIVE_READY_O <= (nxt_state == `ST_DRIVE_READY) & both_on & ~servo_on;
      SERVO_READY_O <= (nxt_state == `ST_SERVO_READY);
      EXTERNAL_MONITOR_OUT_O <= both_off;
      // alarm is sticky until software clears it with inputs agreeing
      if (expired)
        alarm_ff <= 1'b1;
      else if (wr_hit && AVS_ADDRESS_I == `REG_CTRL && AVS_BYTEENABLE_I[0] &&
               AVS_WRITEDATA_I[`CTRL_ALARM_CLR_BIT])
        alarm_ff <= 1'b0;
      SAFETY_INPUT_SKEW_ALARM_O <= expired | alarm_ff;
    end
  end

  // sticky interrupt status; a new event wins over a clear
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      irq_stat_ff <= 2'h0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~clr_bits) | events;
      IRQ_O <= |(((irq_stat_ff & ~clr_bits) | events) & irq_mask_ff);
    end
  end

  assign rd_mux = (AVS_ADDRESS_I == `REG_CTRL) ? {30'h0, 1'b0, sw_servo_on_ff} :
                  (AVS_ADDRESS_I == `REG_STATUS) ?
                  {24'h0, SAFETY_INPUT_SKEW_ALARM_O, EXTERNAL_MONITOR_OUT_O,
                   SAFETY_INPUT_B_I, SAFETY_INPUT_A_I, POWER_ENABLE_O,
                   1'b0, state_ff} :
                  (AVS_ADDRESS_I == `REG_IRQ_STAT) ? {30'h0, irq_stat_ff} :
                  (AVS_ADDRESS_I == `REG_IRQ_MASK) ? {30'h0, irq_mask_ff} :
                  32'h0;

  // avalon slave: one wait cycle, then the answer edge
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      acc_done_ff <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0;
      sw_servo_on_ff <= 1'b0;
      irq_mask_ff <= `IRQ_MASK_RESET;
    end
    else
    begin
      if ((AVS_READ_I || AVS_WRITE_I) && !acc_done_ff)
      begin
        acc_done_ff <= 1'b1;
        AVS_WAITREQUEST_O <= 1'b0;
        if (AVS_READ_I)
          AVS_READDATA_O <= rd_mux;
        if (AVS_WRITE_I && AVS_BYTEENABLE_I[0])
        begin
          if (AVS_ADDRESS_I == `REG_CTRL)
            sw_servo_on_ff <= AVS_WRITEDATA_I[`CTRL_SERVO_ON_BIT];
          else if (AVS_ADDRESS_I == `REG_IRQ_MASK)
            irq_mask_ff <= AVS_WRITEDATA_I[1:0];
        end
      end
      else
      begin
        acc_done_ff <= 1'b0;
        AVS_WAITREQUEST_O <= 1'b1;
      end
    end
  end

endmodule // sto_interlock

//--- sim/sto_interlock_test.sv
// testbench for the torque off interlock
module sto_interlock_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIM = 20;
  logic clk = 0, nrst = 0, guard = 0, stuck = 0, son = 0, rd = 0, wr = 0;
  logic a, b, wrq, pwr, drdy, srdy, mon, alarm, irq;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  int mismatches = 0, n_tests = 0;
  sto_partner relay (.clk_i(clk), .guard_closed_i(guard), .stuck_b_i(stuck), .in_a_o(a),
    .in_b_o(b));
  sto_interlock #(.SKEW_LIMIT(28'd20)) dut (.REF_CLK_I(clk), .NRST_I(nrst),
    .SAFETY_INPUT_A_I(a), .SAFETY_INPUT_B_I(b), .SERVO_ON_REQ_I(son), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wrq), .POWER_ENABLE_O(pwr),
    .DRIVE_READY_O(drdy), .SERVO_READY_O(srdy), .EXTERNAL_MONITOR_OUT_O(mon),
    .SAFETY_INPUT_SKEW_ALARM_O(alarm), .IRQ_O(irq));
  initial forever #20 clk = !clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus access; request held until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= ad; wdat <= d;
    do begin @(posedge clk); n++; end while (wrq !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = rdat;
    rd <= 0; wr <= 0;
  endtask
  // pins: power, drive ready, servo ready, monitor
  task automatic pins(input logic [3:0] exp);
    repeat (3) @(posedge clk);
    chk({28'h0, pwr, drdy, srdy, mon}, {28'h0, exp});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin repeat (5000) @(posedge clk); mismatches++; close_out; end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    pins(4'h1);
    acc(0, 4'h2, 0); chk(q, 0);
    acc(1, 4'h0, 32'h1); acc(0, 4'h0, 0); chk(q, 32'h1);
    guard <= 1; pins(4'h4);
    son <= 1; pins(4'ha);
    acc(0, 4'h4, 0); chk(q[7:0], 8'h3a);
    $display("ready path done");
    guard <= 0; pins(4'h1);
    guard <= 1; pins(4'h0);
    son <= 0; pins(4'h4);
    son <= 1; pins(4'ha);
    $display("latch done");
    chk(irq, 0);
    acc(1, 4'hc, 32'h1); @(posedge clk); chk(irq, 1);
    acc(1, 4'h8, 32'h3); chk(irq, 0);
    $display("interrupt done");
    stuck <= 1; guard <= 0; pins(4'h1);
    guard <= 1; repeat (LIM - 6) @(posedge clk); chk(alarm, 0);
    repeat (10) @(posedge clk); chk(alarm, 1);
    guard <= 0; pins(4'h1);
    acc(0, 4'h8, 0); chk(q, 32'h3);
    acc(1, 4'h0, 32'h3); acc(0, 4'h4, 0); chk(q[7], 0);
    $display("skew done");
    close_out;
  end
endmodule // sto_interlock_test

//--- sim/sto_partner.sv
// safety relay model: two channels that follow the guard switch
module sto_partner (
  input wire logic clk_i,
  input wire logic guard_closed_i,
  input wire logic stuck_b_i,
  output logic in_a_o,
  output logic in_b_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a stuck channel b stands for broken wiring
  always @(posedge clk_i)
  begin
    in_a_o <= guard_closed_i;
    in_b_o <= guard_closed_i & !stuck_b_i;
  end
endmodule // sto_partner

//--- sim/sto_props.sv
// assertion checker for the torque off interlock
module sto_props #(parameter [27:0] SKEW_LIMIT = 28'd20) (
  input wire REF_CLK_I, NRST_I,
  input wire SAFETY_INPUT_A_I, SAFETY_INPUT_B_I, SERVO_ON_REQ_I, AVS_READ_I,
  input wire AVS_WAITREQUEST_O, POWER_ENABLE_O, DRIVE_READY_O, SERVO_READY_O,
  input wire EXTERNAL_MONITOR_OUT_O, SAFETY_INPUT_SKEW_ALARM_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  wire both_off = !SAFETY_INPUT_A_I && !SAFETY_INPUT_B_I;
  logic [27:0] skew_ff;
  // disagreement length, cleared on agreement
  always @(posedge REF_CLK_I or negedge NRST_I)
    if (!NRST_I) skew_ff <= 28'h0;
    else skew_ff <= (SAFETY_INPUT_A_I != SAFETY_INPUT_B_I) ? skew_ff + 28'h1 : 28'h0;
  property p_mon; both_off |=> EXTERNAL_MONITOR_OUT_O; endproperty
  property p_mon_off; !both_off |=> !EXTERNAL_MONITOR_OUT_O; endproperty
  property p_cut; both_off |-> ##[1:2] !POWER_ENABLE_O; endproperty
  property p_son; !SERVO_ON_REQ_I [*2] |-> !POWER_ENABLE_O; endproperty
  property p_dr; DRIVE_READY_O |-> $past(SAFETY_INPUT_A_I && SAFETY_INPUT_B_I && !SERVO_ON_REQ_I);
  endproperty
  property p_sr; $rose(SERVO_READY_O) |-> $past(DRIVE_READY_O); endproperty
  property p_late; skew_ff == SKEW_LIMIT + 3 |-> SAFETY_INPUT_SKEW_ALARM_O; endproperty
  property p_early; $rose(SAFETY_INPUT_SKEW_ALARM_O) |-> skew_ff >= SKEW_LIMIT - 2; endproperty
  property p_wait; AVS_READ_I && AVS_WAITREQUEST_O |-> ##[1:2] !AVS_WAITREQUEST_O; endproperty
  a_mon: assert property (p_mon) else $error("monitor output missing");
  a_mon_off: assert property (p_mon_off) else $error("monitor output stray");
  a_cut: assert property (p_cut) else $error("power not cut");
  a_son: assert property (p_son) else $error("power without servo-on");
  a_dr: assert property (p_dr) else $error("drive ready wrong");
  a_sr: assert property (p_sr) else $error("servo ready not from drive ready");
  a_late: assert property (p_late) else $error("skew alarm late");
  a_early: assert property (p_early) else $error("skew alarm early");
  a_wait: assert property (p_wait) else $error("read not answered");
  c_sr: cover property ($rose(SERVO_READY_O));
  c_mon: cover property ($rose(EXTERNAL_MONITOR_OUT_O));
  c_alarm: cover property ($rose(SAFETY_INPUT_SKEW_ALARM_O));
endmodule // sto_props
bind sto_interlock sto_props #(.SKEW_LIMIT(SKEW_LIMIT)) u_props (.*);
